// file: hw/seq_cfg.svh
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define SEQ_DEPTH        20
`define SEQ_IDX_W        5
`define SEQ_CODE_W       8
`define SEQ_SCAN_NS      1000
`define SEQ_CLK_NS       5
`define SEQ_SCAN_CYCLES  (`SEQ_SCAN_NS / `SEQ_CLK_NS)
`define SEQ_SCAN_W       8
`define EV_FALSE         8'h00
`define EV_TRUE          8'h01
`define EV_ON_REF        8'h04
`define EV_TIMER0_DONE   8'h1e
`define EV_EXT_BASE      8'h40
`define ACT_NONE         8'h01
`define ACT_PRESET0      8'h0a
`define ACT_PRESET1      8'h0b
`define ACT_TIMER0_START 8'h1d
`endif

// file: hw/seq_pkg.sv
`include "seq_cfg.svh"
package seq_pkg;
  typedef logic [`SEQ_CODE_W-1:0] code_t;
  typedef logic [`SEQ_IDX_W-1:0]  idx_t;
  typedef struct packed {
    logic  valid;
    idx_t  index;
    code_t code;
  } action_s;
  typedef struct packed {
    logic       we;
    idx_t       index;
    code_t      event_code;
    code_t      action_code;
  } prog_s;
  typedef enum logic [1:0] {st_off, st_idle, st_run} seq_state_e;
endpackage

// file: hw/event_action_sequencer.sv
// Operation
// RULE_01: on start, test only the first event each scan until it is true.
// RULE_02: event n true performs action n, then event n+1 is tested next scan.
// RULE_03: one event tested per scan; false means no action, nothing else tested.
// RULE_04: zero to twenty pairs may be programmed; storage covers twenty.
// RULE_05: after the last pair, return to the first; sequence repeats forever.
// RULE_06: events and actions sit in two arrays; same index forms one state.
// RULE_07: events from inside the drive or an outside controller both trigger actions.
// RULE_08: runs only while enabled; disabled means no testing and no actions.
// RULE_09: event codes: false 0, true 1, on-reference 4, timer-zero expired 30.
// RULE_10: action codes: none 1, preset zero 10, preset one 11, start timer zero 29.
// RULE_11: zero pairs keeps the sequencer idle; enabling resets index to first pair.
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"
module event_action_sequencer (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // configuration
  input  wire logic             enable,
  input  wire seq_pkg::idx_t    pair_count,
  input  wire seq_pkg::prog_s   prog,
  // event sources
  input  wire logic             on_reference,
  input  wire logic             timer0_expired,
  input  wire logic [7:0]       ext_events,
  // action outputs and current index
  output var  seq_pkg::action_s action,
  output logic                  preset_select,
  output logic                  timer0_start,
  output seq_pkg::idx_t         current_index
);
  import seq_pkg::*;

  // reset is asserted at once but released in step with the clock, so no
  // flip-flop leaves reset on a different edge from its neighbours
  logic rst_meta;
  logic rst_sync_n;
  logic next_rst_meta;
  logic next_rst_sync_n;
  always_comb begin
    next_rst_meta   = 1'b1;
    next_rst_sync_n = rst_meta;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= next_rst_meta;
      rst_sync_n <= next_rst_sync_n;
    end
  end

  // pin-level inputs are asynchronous to the scan clock; each passes two
  // flip-flops before the event decode may look at it
  logic [9:0] ev_meta;
  logic [9:0] ev_sync;
  logic [9:0] next_ev_meta;
  logic [9:0] next_ev_sync;
  always_comb begin
    next_ev_meta = {ext_events, timer0_expired, on_reference};
    next_ev_sync = ev_meta;
  end
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ev_meta <= 10'h000;
      ev_sync <= 10'h000;
    end else begin
      ev_meta <= next_ev_meta;
      ev_sync <= next_ev_sync;
    end
  end

  code_t event_table  [`SEQ_DEPTH]; // RULE_06
  code_t action_table [`SEQ_DEPTH]; // RULE_06
  // writes beyond the last entry are dropped rather than wrapping onto entry 0
  logic  table_we;
  always_comb begin
    table_we = prog.we && (prog.index < `SEQ_IDX_W'(`SEQ_DEPTH)); // RULE_04
  end
  always_ff @(posedge sys_clk) begin
    if (table_we) begin
      event_table[prog.index]  <= prog.event_code;
      action_table[prog.index] <= prog.action_code;
    end
  end

  // scan interval divider; free running from reset, so the first test after
  // enable may come up to one full interval later
  logic [`SEQ_SCAN_W-1:0] scan_cnt;
  logic [`SEQ_SCAN_W-1:0] next_scan_cnt;
  logic                   scan_tick;
  always_comb begin
    scan_tick     = (scan_cnt == `SEQ_SCAN_W'(`SEQ_SCAN_CYCLES - 1));
    next_scan_cnt = scan_tick ? '0 : scan_cnt + 1'b1;
  end
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scan_cnt <= '0;
    end else begin
      scan_cnt <= next_scan_cnt;
    end
  end

  // clamp keeps a too-large count from indexing past storage
  idx_t count_eff;
  always_comb begin
    count_eff = (pair_count > `SEQ_IDX_W'(`SEQ_DEPTH)) ? `SEQ_IDX_W'(`SEQ_DEPTH)
                                                       : pair_count; // RULE_04
  end

  // codes outside the list and the external range 0x40-0x47 read as false, so a stale or mistyped entry stalls
  // the sequence at that pair instead of firing its action
  function automatic logic event_true(input code_t c, input logic [9:0] ev);
    logic r;
    r = 1'b0;
    case (c)
      `EV_FALSE:       r = 1'b0;  // RULE_09
      `EV_TRUE:        r = 1'b1;  // RULE_09
      `EV_ON_REF:      r = ev[0]; // RULE_09
      `EV_TIMER0_DONE: r = ev[1]; // RULE_09
      default: begin
        if (c >= `EV_EXT_BASE && c < `EV_EXT_BASE + 8'h08) begin
          r = ev[2 + c[2:0]]; // RULE_07
        end
      end
    endcase
    return r;
  endfunction

  seq_state_e state;
  seq_state_e next_state;
  idx_t       index;
  idx_t       next_index;
  action_s    next_action;
  logic       hit;
  code_t      act_code;
  // the wrap compares against the clamped count, so a count lowered while
  // running still brings the index back to the first pair at the next hit
  idx_t       index_inc;
  logic       at_last;
  always_comb begin
    index_inc = index + 1'b1;
    at_last   = (index_inc >= count_eff); // RULE_05
  end

  always_comb begin
    next_state  = state;
    next_index  = index;
    next_action = '0;
    hit         = 1'b0;
    act_code    = action_table[index];
    unique case (state)
      st_off: begin
        next_index = '0; // RULE_11
        if (enable) next_state = (count_eff == '0) ? st_idle : st_run;
      end
      st_idle: begin
        next_index = '0; // RULE_11
        if (!enable) next_state = st_off; // RULE_08
        else if (count_eff != '0) next_state = st_run;
      end
      st_run: begin
        if (!enable) begin
          next_state = st_off; // RULE_08
        end else if (count_eff == '0) begin
          next_state = st_idle; // RULE_11
        end else if (scan_tick) begin
          hit = event_true(event_table[index], ev_sync); // RULE_01 RULE_03
          if (hit) begin
            next_action = '{valid: 1'b1, index: index, code: act_code}; // RULE_02
            if (at_last) next_index = '0; // RULE_05
            else next_index = index_inc; // RULE_02
          end
        end
      end
    endcase
  end

  // action leaves reset with state and index, so no stale action follows reset
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state  <= st_off;
      index  <= '0;
      action <= '0;
    end else begin
      state  <= next_state;
      index  <= next_index;
      action <= next_action;
    end
  end

  // preset choice is a level that holds until another preset action
  logic next_preset;
  logic next_t0;
  always_comb begin
    next_preset = preset_select;
    next_t0     = 1'b0;
    if (next_action.valid) begin
      case (next_action.code)
        `ACT_NONE:         next_t0     = 1'b0; // RULE_10
        `ACT_PRESET0:      next_preset = 1'b0; // RULE_10
        `ACT_PRESET1:      next_preset = 1'b1; // RULE_10
        `ACT_TIMER0_START: next_t0     = 1'b1; // RULE_10
        default:           next_t0     = 1'b0;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      preset_select <= 1'b0;
      timer0_start  <= 1'b0;
    end else begin
      preset_select <= next_preset;
      timer0_start  <= next_t0;
    end
  end

  assign current_index = index;
endmodule
`default_nettype wire

// file: tb/seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module seq_checker (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             enable,
  input wire seq_pkg::idx_t    pair_count,
  input wire seq_pkg::action_s action,
  input wire logic             preset_select,
  input wire logic             timer0_start,
  input wire seq_pkg::idx_t    current_index
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire v = action.valid;
  one_test_a: assert property (v |=> !v[*8]) else $error("early action");
  index_adv_a: assert property (v |-> current_index ==
    (action.index == pair_count - 5'h01 ? 5'h00 : action.index + 5'h01)) else $error("bad index");
  index_hold_a: assert property ($changed(current_index) |-> v || !$past(enable))
    else $error("index moved");
  off_idle_a: assert property (!enable[*2] |=> !v && current_index == 5'h00)
    else $error("active while off");
  empty_idle_a: assert property ((pair_count == 5'h00)[*2] |=> !v) else $error("empty act");
  timer_code_a: assert property (timer0_start |-> v && action.code == 8'h1d)
    else $error("timer start");
  preset_zero_a: assert property (v && action.code == 8'h0a |-> !preset_select)
    else $error("preset zero");
  preset_one_a: assert property (v && action.code == 8'h0b |-> preset_select)
    else $error("preset one");
  preset_keep_a: assert property ($changed(preset_select) |-> v) else $error("preset moved");
  cover property (timer0_start);
  cover property (v && current_index == 5'h00 && action.index != 5'h00);
  cover property ($fell(enable));
endmodule
bind event_action_sequencer seq_checker seq_checker_inst (.sys_clk, .rst_n, .enable, .pair_count,
  .action, .preset_select, .timer0_start, .current_index);
`default_nettype wire

// file: tb/drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_model (
  input  wire logic sys_clk,
  input  wire logic preset_select,
  input  wire logic timer0_start,
  output logic      on_reference = 1'b0,
  output logic      timer0_expired = 1'b0
);
  logic [8:0] cnt = 9'h000;
  // expiry is a level held until the timer is started again
  always @(posedge sys_clk) begin
    on_reference <= !preset_select;
    cnt <= timer0_start ? 9'h12c : cnt - 9'(cnt != 9'h000);
    timer0_expired <= (cnt == 9'h001) | (timer0_expired & !timer0_start);
  end
endmodule
`default_nettype wire

// file: tb/event_action_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module event_action_sequencer_tb;
  import seq_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, enable = 1'b0, on_reference, timer0_expired;
  logic preset_select, timer0_start;
  idx_t pair_count = 5'h00, current_index;
  prog_s prog = '0;
  logic [7:0] ext_events = 8'h00;
  action_s action;
  logic [12:0] q[$];
  int n_fail = 0, n_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  event_action_sequencer event_action_sequencer_inst (.sys_clk, .rst_n, .enable, .pair_count,
    .prog, .on_reference, .timer0_expired, .ext_events, .action, .preset_select, .timer0_start,
    .current_index);
  drive_model drive_model_inst (.sys_clk, .preset_select, .timer0_start, .on_reference,
    .timer0_expired);
  task automatic step(int n); repeat (n) @(posedge sys_clk); #1; endtask
  task automatic put(int i, code_t e, code_t a);
    prog = {1'b1, 5'(i), e, a};
    step(1);
    prog.we = 1'b0;
    step(1);
  endtask
  // run until every queued action is seen, then switch off and watch for silence
  task automatic drain();
    for (int k = 0; k < 6000 && q.size() != 0; k++) step(1);
    if (q.size() != 0) begin
      n_fail++;
      $display("[ERR] %0t actions missing", $time);
    end
    q.delete();
    enable = 1'b0;
    step(400);
    n_checks++;
    if (current_index !== 5'h00) begin
      n_fail++;
      $display("[ERR] %0t index not cleared", $time);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) if (action.valid === 1'b1) begin
    n_checks++;
    if (q.size() == 0 || {action.index, action.code} !== q[0]) begin
      n_fail++;
      $display("[ERR] %0t unexpected action %h", $time, action);
    end else begin
      n_checks += 2;
      if (current_index !== 5'((int'(q[0][12:8]) + 1) % int'(pair_count))) begin
        n_fail++;
        $display("[ERR] %0t wrong next index %0d", $time, current_index);
      end
      if (timer0_start !== (q[0][7:0] == 8'h1d)) begin
        n_fail++;
        $display("[ERR] %0t timer start %b", $time, timer0_start);
      end
      if (q[0][7:0] == 8'h0a || q[0][7:0] == 8'h0b) begin
        n_checks++;
        if (preset_select !== (q[0][7:0] == 8'h0b)) begin
          n_fail++;
          $display("[ERR] %0t preset level %b", $time, preset_select);
        end
      end
    end
    if (q.size() != 0) void'(q.pop_front());
  end
  initial begin
    int k;
    code_t ev[4], ac[4], r[20];
    void'($urandom(16));
    k = $urandom % 8;
    ev = '{8'h01, 8'h04, 8'h1e, 8'(8'h40 + k)};
    ac = '{8'h0a, 8'h1d, 8'h0b, 8'h01};
    step(10);
    rst_n = 1'b1;
    step(3);
    ext_events[k] = 1'b1;
    pair_count = 5'h04;
    for (int i = 0; i < 4; i++) put(i, ev[i], ac[i]);
    for (int i = 0; i < 8; i++) q.push_back({5'(i % 4), ac[i % 4]});
    enable = 1'b1;
    drain();
    pair_count = 5'h00;
    enable = 1'b1;
    step(600);
    n_checks++;
    if (current_index !== 5'h00) begin
      n_fail++;
      $display("[ERR] %0t idle index moved", $time);
    end
    put(0, 8'h00, 8'h0b);
    pair_count = 5'h01;
    step(600);
    drain();
    pair_count = 5'h14;
    for (int i = 0; i < 20; i++) begin
      r[i] = 8'($urandom);
      put(i, 8'h01, r[i]);
      q.push_back({5'(i), r[i]});
    end
    q.push_back({5'h00, r[0]});
    enable = 1'b1;
    drain();
    conclude();
  end
  initial begin
    #100us;
    n_fail++;
    $display("[ERR] %0t timeout", $time);
    conclude();
  end
endmodule
`default_nettype wire
